// file: include/esi_flash_if.sv
// Flash phase bus from the shared flash timer to the lamp drivers.
// Assumes all parties sit on sys_clk.
`timescale 1ns/1ps
`default_nettype none
interface esi_flash_if;
  logic phase_on; // High: lamp pulled low this half period
  logic wrap;     // One-cycle pulse at each half period boundary
  modport src (output phase_on, output wrap);
  modport snk (input phase_on, input wrap);
endinterface : esi_flash_if
`default_nettype wire

// file: include/esi_pkg.sv
// Constants shared by the status indicator block of the 10 Mb/s transceiver.
// Assumes a single 250 MHz reference clock for every timing figure below.
package esi_pkg;
  // Clock rate in MHz
  localparam int unsigned CLK_MHZ        = 250;
  // Half of one lamp flash period in ms (10 Hz, 50% duty)
  localparam int unsigned FLASH_HALF_MS  = 50;
  // Half period in clock cycles, derived from time and rate
  localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * 1000 * CLK_MHZ;
  // Flash counter width, holds FLASH_HALF_CYC
  localparam int          FLASH_W        = 24;
  // Lamp count and lamp indices
  localparam int          NUM_LAMPS      = 3;
  localparam int          LAMP_TX        = 0;
  localparam int          LAMP_RX        = 1;
  localparam int          LAMP_CL        = 2;
  // Pin levels after reset: released, level high
  localparam logic        RST_PIN_O      = 1'h1;
  localparam logic        RST_PIN_OE     = 1'h0;
  localparam logic        RST_PHASE      = 1'h0;
  localparam logic [FLASH_W-1:0] RST_CNT = 24'h000000;
  // Polarity fault tracking states
  typedef enum logic {
    POL_OK,
    POL_FAULT
  } esi_pol_t;
endpackage

// file: sim/esi_pin_model.sv
// Board side of the status pins: lamp pull-ups and a monitor that sees pin levels.
// Assumes pin outputs and enables come from the status block on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module esi_pin_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // Pin drive from the block: 0 tx, 1 rx, 2 coll, 3 link, 4 fault, 5 jabber
  input  wire logic [5:0] pin_o,
  input  wire logic [5:0] pin_oe,
  // Resolved wire levels
  output logic      [5:0] lvl
);
  logic [5:0] last_ff; // Last driven level of each pin

  // Remember what each pin last carried
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < 6; i++) begin
      if (sys_rst) begin
        last_ff[i] <= 1'h0;
      end else if (pin_oe[i]) begin
        last_ff[i] <= pin_o[i];
      end
    end
  end

  // Lamps float to the pull-up (off); status pins have none, so a released
  // pin shows a flipped level rather than a kind stale one
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      lvl[i] = pin_oe[i] ? pin_o[i] : ((i < 3) ? 1'h1 : ~last_ff[i]);
    end
  end
endmodule // esi_pin_model
`default_nettype wire

// file: sim/ethernet_status_indicators_tb.sv
// Self-checking bench for the status indicator top with a short flash count.
// Assumes the pin model resolves released lamp pins to high.
`timescale 1ns/1ps
`default_nettype none
module ethernet_status_indicators_tb
  import esi_pkg::*;
;
  localparam logic [FLASH_W-1:0] HALF  = 24'h000008; // Short flash half period
  localparam int                 LIMIT = 4000;       // Cycle ceiling for the run
  logic       sys_clk, sys_rst, standby_pin, autofix, tp_sel;
  logic       link_ok, rev, jab;
  logic [2:0] act_tp, act_aui; // Activity per port: tx, rx, coll
  logic [5:0] po, poe, lvl;    // Pin drive, enables, resolved levels
  int         fail_count, checks_done, cyc;

  esi_status_top #(.FLASH_HALF(HALF)) dut_u (
    .sys_clk                  (sys_clk),
    .sys_rst                  (sys_rst),
    .standby_pin              (standby_pin),
    .polarity_autofix_enable  (autofix),
    .tp_port_sel              (tp_sel),
    .tx_act_tp                (act_tp[0]),
    .tx_act_aui               (act_aui[0]),
    .rx_act_tp                (act_tp[1]),
    .rx_act_aui               (act_aui[1]),
    .coll_act_tp              (act_tp[2]),
    .coll_act_aui             (act_aui[2]),
    .pair_link_ok             (link_ok),
    .pair_rx_reversed         (rev),
    .pair_jabber              (jab),
    .transmit_activity_lamp_o (po[0]),
    .transmit_activity_lamp_oe(poe[0]),
    .receive_activity_lamp_o  (po[1]),
    .receive_activity_lamp_oe (poe[1]),
    .collision_lamp_o         (po[2]),
    .collision_lamp_oe        (poe[2]),
    .pair_link_good_n_o       (po[3]),
    .pair_link_good_n_oe      (poe[3]),
    .pair_polarity_fault_n_o  (po[4]),
    .pair_polarity_fault_n_oe (poe[4]),
    .pair_jabber_flag_o       (po[5]),
    .pair_jabber_flag_oe      (poe[5])
  );

  esi_pin_model model_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .pin_o(po), .pin_oe(poe),
                         .lvl(lvl));

  // Free-running 4 ns clock
  initial begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Expected {oe, o} of a twisted-pair status pin
  function automatic logic [1:0] exp_stat(input logic sel, input logic val);
    return {sel, sel & val};
  endfunction

  // Expected low cycles over a span: half of it while flashing
  function automatic logic [7:0] exp_flash(input logic on, input int span);
    return on ? 8'(span / 2) : 8'h00;
  endfunction

  // Longest steady stretch: one half period while flashing, all of it when dark
  function automatic logic [7:0] exp_run(input logic on, input int span);
    return on ? 8'(HALF) : 8'(span);
  endfunction

  // Wait n edges, then step just past the edge
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Compare seen against expected and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Closing report
  task automatic summarize;
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watch one lamp over two full flash periods (32 cycles at HALF 8)
  task automatic lamp_run(input int idx, input logic on);
    int   lows;
    int   oes;
    int   run;
    int   maxrun;
    logic prev;
    lows   = 0;
    oes    = 0;
    run    = 0;
    maxrun = 0;
    step(2);
    prev = lvl[idx];
    repeat (32) begin
      lows += (lvl[idx] === 1'h0) ? 1 : 0;
      oes  += (poe[idx] === 1'h1) ? 1 : 0;
      run    = (lvl[idx] === prev) ? run + 1 : 1;
      maxrun = (run > maxrun) ? run : maxrun;
      prev   = lvl[idx];
      step(1);
    end
    check(8'(maxrun), exp_run(on, 32));
    check(8'(lows), exp_flash(on, 32));
    check(8'(oes), on ? 8'h20 : 8'h00);
  endtask

  // Hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fail_count++;
      summarize();
    end
  end

  // Main sequence
  initial begin
    sys_rst = 1'h1; standby_pin = 1'h0; autofix = 1'h0; tp_sel = 1'h1;
    act_tp = 3'h0; act_aui = 3'h0; link_ok = 1'h0; rev = 1'h0; jab = 1'h0;
    fail_count = 0; checks_done = 0; cyc = 0;
    void'($urandom(9985));
    step(3);
    check({1'h0, poe, po[5]}, 8'h00);
    sys_rst = 1'h0;
    $display("test reset done");
    // Each lamp on each port: selected port flashes, other port is ignored
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i < 3; i++) begin
        tp_sel = s[0]; act_tp = 3'h0; act_aui = 3'h0;
        if (s == 1) act_tp[i] = 1'h1; else act_aui[i] = 1'h1;
        lamp_run(i, 1'h1);
        act_tp = 3'h0; act_aui = 3'h0;
        if (s == 1) act_aui[i] = 1'h1; else act_tp[i] = 1'h1;
        lamp_run(i, 1'h0);
      end
    end
    $display("test lamps done");
    // Random port, link and jabber mixes
    repeat (40) begin
      tp_sel = 1'($urandom); link_ok = 1'($urandom); jab = 1'($urandom);
      act_tp = 3'($urandom); act_aui = 3'($urandom);
      step(2);
      check({6'h0, poe[3], poe[3] & po[3]}, {6'h0, exp_stat(tp_sel, ~link_ok)});
      check({6'h0, poe[5], poe[5] & po[5]}, {6'h0, exp_stat(tp_sel, jab)});
      check({7'h0, poe[4]}, {7'h0, tp_sel});
      if (tp_sel && !link_ok) check({7'h0, po[4]}, 8'h01);
    end
    $display("test random status done");
    // Polarity fault: set, held after correction, cleared by failed link
    act_tp = 3'h0; act_aui = 3'h0; jab = 1'h0; tp_sel = 1'h1; link_ok = 1'h1; rev = 1'h1;
    step(4);
    check({7'h0, po[4]}, 8'h01);
    autofix = 1'h1;
    step(5);
    check({7'h0, lvl[4]}, 8'h00);
    rev = 1'h0;
    step(4);
    check({7'h0, lvl[4]}, 8'h00);
    link_ok = 1'h0;
    step(2);
    check({7'h0, lvl[4]}, 8'h01);
    $display("test polarity done");
    // Jabber flashes the collision lamp with no collision seen
    jab = 1'h1;
    lamp_run(2, 1'h1);
    check({7'h0, lvl[5]}, 8'h01);
    jab = 1'h0;
    step(2);
    check({7'h0, lvl[5]}, 8'h00);
    $display("test jabber done");
    // Standby floats everything even with activity and link present
    act_tp = 3'h7; link_ok = 1'h1; jab = 1'h1; standby_pin = 1'h1;
    step(4);
    check({2'h0, poe}, 8'h00);
    standby_pin = 1'h0;
    step(4);
    check({7'h0, poe[3]}, 8'h01);
    $display("test standby done");
    // Reset in mid-run: pins released, then the flash restarts in its dark half
    sys_rst = 1'h1;
    step(3);
    check({2'h0, poe}, 8'h00);
    sys_rst = 1'h0;
    step(2);
    check({6'h0, poe[0], lvl[0]}, 8'h03);
    $display("test mid-run reset done");
    summarize();
  end
endmodule // ethernet_status_indicators_tb
`default_nettype wire

// file: src/esi_flash_timer.sv
// Free-running half-period counter giving the 10 Hz lamp flash phase.
// Assumes sys_clk at the package rate; HALF_CYC may be shortened in sim.
`timescale 1ns/1ps
`default_nettype none
module esi_flash_timer
  import esi_pkg::*;
#(
  parameter logic [FLASH_W-1:0] HALF_CYC = FLASH_W'(FLASH_HALF_CYC)
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Phase out
  esi_flash_if.src  flash
);
  logic [FLASH_W-1:0] cnt_ff; // Cycles into current half period
  logic               ph_ff;  // Current flash phase
  logic               wr_ff;  // Boundary pulse

  // Count cycles, wrap on the half period
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_ff <= RST_CNT;
    end else if (cnt_ff == HALF_CYC - 1'h1) begin
      cnt_ff <= RST_CNT;
    end else begin
      cnt_ff <= cnt_ff + 1'h1;
    end
  end

  // Toggle phase at each wrap; equal halves give 50% duty
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ph_ff <= RST_PHASE;
      wr_ff <= 1'h0;
    end else begin
      wr_ff <= (cnt_ff == HALF_CYC - 1'h1);
      if (cnt_ff == HALF_CYC - 1'h1) begin
        ph_ff <= ~ph_ff;
      end
    end
  end

  assign flash.phase_on = ph_ff;
  assign flash.wrap     = wr_ff;

  flash_toggle_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cnt_ff == HALF_CYC - 1'h1) |=> (ph_ff != $past(ph_ff)) && wr_ff)
    else $error("flash phase did not toggle at half period end");
endmodule : esi_flash_timer
`default_nettype wire

// file: src/esi_lamp_drv.sv
// One activity lamp pin driver: flashes while active, released otherwise.
// Assumes an external pull-up holds the pin high (off) while released.
`timescale 1ns/1ps
`default_nettype none
module esi_lamp_drv
  import esi_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Conditions
  input  wire logic active,
  input  wire logic standby,
  esi_flash_if.snk  flash,
  // Lamp pin
  output logic      lamp_o,
  output logic      lamp_oe
);
  // Drive the pin while active; low in the on half, high in the off half
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      lamp_o  <= RST_PIN_O;
      lamp_oe <= RST_PIN_OE;
    end else if (standby || !active) begin
      lamp_o  <= RST_PIN_O;
      lamp_oe <= RST_PIN_OE;
    end else begin
      lamp_o  <= ~flash.phase_on;
      lamp_oe <= 1'h1;
    end
  end
endmodule : esi_lamp_drv
`default_nettype wire

// file: src/esi_status_top.sv
// Status indicator outputs of the 10 Mb/s transceiver: three flashing
// activity lamps and three twisted-pair status pins.
// Assumes core conditions arrive on sys_clk; mode pins are asynchronous.
// How it works
// - Lamps follow selected port, else released high
// - Transmit lamp flashes low, 10 Hz, 50%
// - Receive lamp flashes low, 10 Hz, 50%
// - Collision lamp flashes low, 10 Hz, 50%
// - Standby floats every status and lamp output
// - Link pin low while pair link good
// - Link pin high when pair link fails
// - Link pin floats with attachment port selected
// - Reversed pair with autofix drives fault low
// - Fault stays low after automatic correction
// - Failed link tests drive fault pin high
// - Jabber pin high during jabber, else low
// - Jabber also flashes the collision lamp
// - Attachment port floats fault and jabber pins
`timescale 1ns/1ps
`default_nettype none
module esi_status_top
  import esi_pkg::*;
#(
  parameter logic [FLASH_W-1:0] FLASH_HALF = FLASH_W'(FLASH_HALF_CYC)
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Mode pins, asynchronous
  input  wire logic standby_pin,
  input  wire logic polarity_autofix_enable,
  // Port selection from the port logic, high for twisted pair
  input  wire logic tp_port_sel,
  // Activity from each port's core
  input  wire logic tx_act_tp,
  input  wire logic tx_act_aui,
  input  wire logic rx_act_tp,
  input  wire logic rx_act_aui,
  input  wire logic coll_act_tp,
  input  wire logic coll_act_aui,
  // Twisted pair core conditions
  input  wire logic pair_link_ok,
  input  wire logic pair_rx_reversed,
  input  wire logic pair_jabber,
  // Activity lamps
  output logic      transmit_activity_lamp_o,
  output logic      transmit_activity_lamp_oe,
  output logic      receive_activity_lamp_o,
  output logic      receive_activity_lamp_oe,
  output logic      collision_lamp_o,
  output logic      collision_lamp_oe,
  // Twisted pair status pins
  output logic      pair_link_good_n_o,
  output logic      pair_link_good_n_oe,
  output logic      pair_polarity_fault_n_o,
  output logic      pair_polarity_fault_n_oe,
  output logic      pair_jabber_flag_o,
  output logic      pair_jabber_flag_oe
);

  // Synchroniser stages for the asynchronous mode pins
  logic     stby_m_ff;  // Standby, first stage
  logic     stby_s_ff;  // Standby, usable
  logic     afx_m_ff;   // Autofix enable, first stage
  logic     afx_s_ff;   // Autofix enable, usable

  // Selected per-kind activity, one bit per lamp
  logic [NUM_LAMPS-1:0] act_sel;
  // Lamp pin pairs from the drivers
  logic [NUM_LAMPS-1:0] lamp_o;
  logic [NUM_LAMPS-1:0] lamp_oe;

  // Polarity fault tracking
  esi_pol_t pol_ff;     // Fault seen on the current link
  esi_pol_t nxt_pol;    // Next tracking state
  logic     pol_set;    // Reversal seen while reporting enabled
  logic     pol_clr;    // Link lost or reporting disabled

  // Shared flash phase
  esi_flash_if flash_bus ();

  // Pair status pins are released in standby or off the pair port;
  // shared so the three pin processes cannot drift apart
  function automatic logic pair_pins_off(input logic stby, input logic tp_sel);
    return stby || !tp_sel;
  endfunction

  // Two-stage synchronisers; only the second stage is read
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stby_m_ff <= 1'h0;
      stby_s_ff <= 1'h0;
      afx_m_ff  <= 1'h0;
      afx_s_ff  <= 1'h0;
    end else begin
      stby_m_ff <= standby_pin;
      stby_s_ff <= stby_m_ff;
      afx_m_ff  <= polarity_autofix_enable;
      afx_s_ff  <= afx_m_ff;
    end
  end

  // Pick the activity of the selected port only
  // Port select shares sys_clk, so it is read without a synchroniser
  always_comb begin
    act_sel[LAMP_TX] = tp_port_sel ? tx_act_tp : tx_act_aui;
    act_sel[LAMP_RX] = tp_port_sel ? rx_act_tp : rx_act_aui;
    // Jabber exists only on the pair port; it also lights the collision lamp
    act_sel[LAMP_CL] = tp_port_sel ? (coll_act_tp || pair_jabber)
                                   : coll_act_aui;
  end

  // One timer feeds all lamps so they flash in step
  esi_flash_timer #(
    .HALF_CYC (FLASH_HALF)
  ) u_timer (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .flash   (flash_bus)
  );

  // One driver per lamp
  generate
    for (genvar i = 0; i < NUM_LAMPS; i++) begin : g_lamp
      esi_lamp_drv u_lamp (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .active  (act_sel[i]),
        .standby (stby_s_ff),
        .flash   (flash_bus),
        .lamp_o  (lamp_o[i]),
        .lamp_oe (lamp_oe[i])
      );
    end
  endgenerate

  // Lamp pins straight from the driver flops
  assign transmit_activity_lamp_o  = lamp_o[LAMP_TX];
  assign transmit_activity_lamp_oe = lamp_oe[LAMP_TX];
  assign receive_activity_lamp_o   = lamp_o[LAMP_RX];
  assign receive_activity_lamp_oe  = lamp_oe[LAMP_RX];
  assign collision_lamp_o          = lamp_o[LAMP_CL];
  assign collision_lamp_oe         = lamp_oe[LAMP_CL];

  // Link pin: active low while good, floated off the pair port
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pair_link_good_n_o  <= RST_PIN_O;
      pair_link_good_n_oe <= RST_PIN_OE;
    end else if (pair_pins_off(stby_s_ff, tp_port_sel)) begin
      pair_link_good_n_o  <= RST_PIN_O;
      pair_link_good_n_oe <= RST_PIN_OE;
    end else begin
      pair_link_good_n_o  <= !pair_link_ok;
      pair_link_good_n_oe <= 1'h1;
    end
  end

  // Fault conditions; reporting needs the autofix enable held high
  assign pol_set = afx_s_ff && pair_rx_reversed && pair_link_ok;
  assign pol_clr = !pair_link_ok || !afx_s_ff;

  // Tracking state: a new reversal wins over a clear in the same cycle.
  // Correction leaves the reversal flag, so the fault is held until the
  // link drops or the autofix enable goes low, rather than following the core's corrected view.
  always_comb begin
    nxt_pol = pol_ff;
    unique case (pol_ff)
      POL_OK: begin
        if (pol_set) begin
          nxt_pol = POL_FAULT;
        end
      end
      POL_FAULT: begin
        if (!pol_set && pol_clr) begin
          nxt_pol = POL_OK;
        end
      end
    endcase
  end

  // Fault state register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pol_ff <= POL_OK;
    end else begin
      pol_ff <= nxt_pol;
    end
  end

  // Polarity pin: low while a fault is held, high when link fails
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pair_polarity_fault_n_o  <= RST_PIN_O;
      pair_polarity_fault_n_oe <= RST_PIN_OE;
    end else if (pair_pins_off(stby_s_ff, tp_port_sel)) begin
      pair_polarity_fault_n_o  <= RST_PIN_O;
      pair_polarity_fault_n_oe <= RST_PIN_OE;
    end else if (!pair_link_ok) begin
      // A failed link outranks any held fault
      pair_polarity_fault_n_o  <= 1'h1;
      pair_polarity_fault_n_oe <= 1'h1;
    end else begin
      // Next state is used so the pin follows detection in one cycle
      pair_polarity_fault_n_o  <= !(nxt_pol == POL_FAULT);
      pair_polarity_fault_n_oe <= 1'h1;
    end
  end

  // Jabber pin: active high, floated off the pair port
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pair_jabber_flag_o  <= 1'h0;
      pair_jabber_flag_oe <= RST_PIN_OE;
    end else if (pair_pins_off(stby_s_ff, tp_port_sel)) begin
      pair_jabber_flag_o  <= 1'h0;
      pair_jabber_flag_oe <= RST_PIN_OE;
    end else begin
      pair_jabber_flag_o  <= pair_jabber;
      pair_jabber_flag_oe <= 1'h1;
    end
  end

  // Checks on the driven pins
  lamp_release_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!act_sel[LAMP_TX] && !act_sel[LAMP_RX])
      |=> !transmit_activity_lamp_oe && !receive_activity_lamp_oe)
    else $error("idle lamp still driven");

  tx_flash_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (act_sel[LAMP_TX] && !stby_s_ff)
      |=> transmit_activity_lamp_oe
          && (transmit_activity_lamp_o == !$past(flash_bus.phase_on)))
    else $error("transmit lamp not flashing with phase");

  rx_flash_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (act_sel[LAMP_RX] && !stby_s_ff) ##1 (act_sel[LAMP_RX] && !stby_s_ff)
      |=> receive_activity_lamp_oe
          && ((receive_activity_lamp_o != $past(receive_activity_lamp_o))
              == $past(flash_bus.wrap)))
    else $error("receive lamp phase mismatch");

  coll_flash_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (tp_port_sel && coll_act_tp && !stby_s_ff && flash_bus.phase_on)
      |=> collision_lamp_oe && !collision_lamp_o)
    else $error("collision lamp not low in on phase");

  standby_float_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    stby_s_ff |=> !(lamp_oe != '0 || pair_link_good_n_oe
                    || pair_polarity_fault_n_oe || pair_jabber_flag_oe))
    else $error("output driven in standby");

  link_good_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (tp_port_sel && !stby_s_ff && pair_link_ok)
      |=> pair_link_good_n_oe && !pair_link_good_n_o)
    else $error("link pin not low with good link");

  link_fail_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (tp_port_sel && !stby_s_ff && !pair_link_ok)
      |=> pair_link_good_n_oe && pair_link_good_n_o)
    else $error("link pin not high after link failure");

  link_aui_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !tp_port_sel |=> !pair_link_good_n_oe)
    else $error("link pin driven on attachment port");

  pol_fault_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (pol_set && tp_port_sel && !stby_s_ff)
      |=> pair_polarity_fault_n_oe && !pair_polarity_fault_n_o)
    else $error("reversed pair not reported");

  pol_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (pol_ff == POL_FAULT && afx_s_ff && pair_link_ok && tp_port_sel
     && !stby_s_ff) |=> !pair_polarity_fault_n_o)
    else $error("fault cleared by correction");

  pol_linkfail_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (tp_port_sel && !stby_s_ff && !pair_link_ok) |=> pair_polarity_fault_n_o)
    else $error("fault pin not high on failed link");

  jabber_pin_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (tp_port_sel && !stby_s_ff)
      |=> pair_jabber_flag_oe && (pair_jabber_flag_o == $past(pair_jabber)))
    else $error("jabber pin not following jabber");

  jabber_lamp_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (tp_port_sel && pair_jabber && !stby_s_ff) |=> collision_lamp_oe)
    else $error("jabber not shown on collision lamp");

  aui_float_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !tp_port_sel |=> !pair_polarity_fault_n_oe && !pair_jabber_flag_oe)
    else $error("pair status pins driven on attachment port");

  coll_dark_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (tp_port_sel && coll_act_tp && !stby_s_ff && !flash_bus.phase_on)
      |=> collision_lamp_oe && collision_lamp_o)
    else $error("collision lamp not high in off phase");

  coll_release_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !act_sel[LAMP_CL] |=> !collision_lamp_oe && collision_lamp_o)
    else $error("idle collision lamp still driven");

  jabber_phase_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (tp_port_sel && pair_jabber && !stby_s_ff)
      |=> collision_lamp_o == !$past(flash_bus.phase_on))
    else $error("jabber not flashing collision lamp");

  pol_corrected_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!pair_polarity_fault_n_o && pair_polarity_fault_n_oe && !pair_rx_reversed
     && afx_s_ff && pair_link_ok && tp_port_sel && !stby_s_ff)
      |=> !pair_polarity_fault_n_o)
    else $error("fault cleared after wiring corrected");

endmodule : esi_status_top
`default_nettype wire
